// ===== dpsc_pkg.sv
// Behaviour
// - fixed control word bit layout
// - address bits pick input registers
// - control bits transfer on chip-select rise
// - all-zero address and control is NOP
// - zero control loads input registers only
// - unaddressed input register keeps its contents
// - input-select bit picks control input
// - force-type bit picks voltage or current
// - measure-type bit picks current or voltage
// - force float bit low floats driver
// - range decode, code 110 selects external
// - clamp bit enables force clamps
// - measure drives only when bit and pin high
// - serial out from last stage, falling edge
// - first bit out 15.5 clocks later
// - chip-select pulse without clocks loads both
// - comparator enable bit low floats both flags
// - flags pull low outside threshold window
// - load pin low copies input to unit
// - data latched while load low passes through
// - outputs float after power-up
package dpsc_pkg;
   localparam int WORD_W       = 16;
   localparam int UNITS        = 2;
   localparam int SYNC_W       = 10;
   localparam int B_IN_SEL     = 15;
   localparam int B_FORCE_TYPE = 14;
   localparam int B_MEAS_TYPE  = 13;
   localparam int B_RANGE_HI   = 12;
   localparam int B_RANGE_LO   = 10;
   localparam int B_CLAMP      = 9;
   localparam int B_FORCE_FLT  = 8;
   localparam int B_MEAS_FLT   = 7;
   localparam int B_CMP_EN     = 6;
   localparam int B_ADDR_LO    = 2;
   localparam int B_XFER_LO    = 0;
   localparam logic [15:0] WORD_RST  = 16'h0000;
   localparam logic [2:0]  RANGE_EXT = 3'h6;
   // pins idle: chip select and load high, serial clock low
   localparam logic [SYNC_W-1:0] SYNC_RST = 10'h009;

   typedef enum logic [2:0] {
      RNG_2UA,
      RNG_20UA,
      RNG_200UA,
      RNG_2MA,
      RNG_25MA,
      RNG_EXT
   } dpsc_range_e;

   function automatic dpsc_range_e dpsc_range(input logic [2:0] code);
      unique case (code)
         3'h0, 3'h1: dpsc_range = RNG_2UA;
         3'h2:       dpsc_range = RNG_20UA;
         3'h3:       dpsc_range = RNG_200UA;
         3'h4:       dpsc_range = RNG_2MA;
         3'h6:       dpsc_range = RNG_EXT;
         default:    dpsc_range = RNG_25MA;
      endcase
   endfunction
endpackage

// ===== dpsc_serial_ctrl.sv
`timescale 1ns/1ps
module dpsc_serial_ctrl
   import dpsc_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_cs_n,
   input  wire logic             i_sclk,
   input  wire logic             i_din,
   input  wire logic             i_load_n,
   input  wire logic [UNITS-1:0] i_measure_float_pin_n,
   input  wire logic [UNITS-1:0] i_above_upper,
   input  wire logic [UNITS-1:0] i_below_lower,
   output logic                  o_dout,
   output logic [UNITS-1:0]      o_input_select_bit,
   output logic [UNITS-1:0]      o_force_current,
   output logic [UNITS-1:0]      o_measure_voltage,
   output logic [2:0]            o_range_a,
   output logic [2:0]            o_range_b,
   output logic                  o_ext_range_sel_a,
   output logic                  o_ext_range_sel_b,
   output logic [UNITS-1:0]      o_clamp_on,
   output logic [UNITS-1:0]      o_force_drive,
   output logic [UNITS-1:0]      o_measure_drive,
   output logic [UNITS-1:0]      o_over_limit_flag_n,
   output logic [UNITS-1:0]      o_over_limit_oe_n,
   output logic [UNITS-1:0]      o_under_limit_flag_n,
   output logic [UNITS-1:0]      o_under_limit_oe_n
);

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // pin synchronisers; meta_q is read only by sync_q
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic              sclk_prev_q;
   logic              cs_prev_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q      <= SYNC_RST;
         sync_q      <= SYNC_RST;
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         meta_q      <= {i_below_lower, i_above_upper, i_measure_float_pin_n,
                         i_load_n, i_din, i_sclk, i_cs_n};
         sync_q      <= meta_q;
         sclk_prev_q <= sync_q[1];
         cs_prev_q   <= sync_q[0];
      end
   end

   logic             cs_n_s;
   logic             sclk_s;
   logic             din_s;
   logic             load_n_s;
   logic [UNITS-1:0] mflt_s;
   logic [UNITS-1:0] above_s;
   logic [UNITS-1:0] below_s;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             cs_rise;

   assign cs_n_s    = sync_q[0];
   assign sclk_s    = sync_q[1];
   assign din_s     = sync_q[2];
   assign load_n_s  = sync_q[3];
   assign mflt_s    = sync_q[5:4];
   assign above_s   = sync_q[7:6];
   assign below_s   = sync_q[9:8];
   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s & sclk_prev_q;
   assign cs_rise   = cs_n_s & ~cs_prev_q;

   // serial shift register, MSB first
   logic [WORD_W-1:0] shift_q;
   logic              active_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         shift_q <= WORD_RST;
      end else if (!cs_n_s && sclk_rise) begin
         shift_q <= {shift_q[WORD_W-2:0], din_s};
      end
   end

   // clock activity seen in this frame; cleared as the frame opens
   // an edge in the opening cycle still counts, so set wins
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         active_q <= 1'b0;
      end else if (!cs_n_s && (sclk_rise || sclk_fall)) begin
         active_q <= 1'b1;
      end else if (cs_prev_q && !cs_n_s) begin
         active_q <= 1'b0;
      end
   end

   // daisy-chain output; the next device samples it on the next rise
   logic dout_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         dout_q <= 1'b0;
      end else if (sclk_fall) begin
         dout_q <= shift_q[WORD_W-1];
      end
   end

   assign o_dout = dout_q;

   // two-rank registers
   logic [WORD_W-1:0] in_q   [UNITS];
   logic [WORD_W-1:0] unit_q [UNITS];
   logic [WORD_W-1:0] in_d   [UNITS];
   logic [UNITS-1:0]  addr;
   logic [UNITS-1:0]  xfer;
   logic [UNITS-1:0]  in_ld;
   logic [UNITS-1:0]  unit_ld;

   assign addr = shift_q[B_ADDR_LO+1:B_ADDR_LO];
   assign xfer = shift_q[B_XFER_LO+1:B_XFER_LO];

   always_comb begin
      for (int u = 0; u < UNITS; u++) begin
         in_ld[u]   = cs_rise && active_q && addr[u];
         in_d[u]    = in_ld[u] ? shift_q : in_q[u];
         unit_ld[u] = !load_n_s
                      || (cs_rise && !active_q)
                      || (cs_rise && xfer[u]);
      end
   end

   // all-zero reset word floats force, measure and comparators
   always_ff @(posedge i_clk) begin
      for (int u = 0; u < UNITS; u++) begin
         if (i_reset) begin
            in_q[u]   <= WORD_RST;
            unit_q[u] <= WORD_RST;
         end else begin
            in_q[u] <= in_d[u];
            if (unit_ld[u]) begin
               unit_q[u] <= in_d[u];
            end
         end
      end
   end

   // decoded unit controls
   logic [UNITS-1:0] force_on;
   logic [UNITS-1:0] meas_on;
   logic [UNITS-1:0] cmp_on;
   logic [UNITS-1:0] clamp_on;

   always_comb begin
      for (int u = 0; u < UNITS; u++) begin
         force_on[u] = unit_q[u][B_FORCE_FLT];
         meas_on[u]  = unit_q[u][B_MEAS_FLT] & mflt_s[u];
         cmp_on[u]   = unit_q[u][B_CMP_EN];
         clamp_on[u] = unit_q[u][B_CLAMP];
      end
   end

   logic [UNITS-1:0] in_sel_q;
   logic [UNITS-1:0] force_i_q;
   logic [UNITS-1:0] meas_v_q;
   logic [UNITS-1:0] clamp_q;
   logic [UNITS-1:0] force_drv_q;
   logic [UNITS-1:0] meas_drv_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         in_sel_q    <= 2'h0;
         force_i_q   <= 2'h0;
         meas_v_q    <= 2'h0;
         clamp_q     <= 2'h0;
         force_drv_q <= 2'h0;
         meas_drv_q  <= 2'h0;
      end else begin
         for (int u = 0; u < UNITS; u++) begin
            in_sel_q[u]  <= unit_q[u][B_IN_SEL];
            force_i_q[u] <= unit_q[u][B_FORCE_TYPE];
            meas_v_q[u]  <= unit_q[u][B_MEAS_TYPE];
         end
         clamp_q     <= clamp_on;
         force_drv_q <= force_on;
         meas_drv_q  <= meas_on;
      end
   end

   assign o_input_select_bit = in_sel_q;
   assign o_force_current    = force_i_q;
   assign o_measure_voltage  = meas_v_q;
   assign o_clamp_on         = clamp_q;
   assign o_force_drive      = force_drv_q;
   assign o_measure_drive    = meas_drv_q;

   // range decode
   dpsc_range_e range_a_q;
   dpsc_range_e range_b_q;
   logic        ext_a_q;
   logic        ext_b_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         range_a_q <= RNG_2UA;
         range_b_q <= RNG_2UA;
         ext_a_q   <= 1'b0;
         ext_b_q   <= 1'b0;
      end else begin
         range_a_q <= dpsc_range(unit_q[0][B_RANGE_HI:B_RANGE_LO]);
         range_b_q <= dpsc_range(unit_q[1][B_RANGE_HI:B_RANGE_LO]);
         ext_a_q   <= unit_q[0][B_RANGE_HI:B_RANGE_LO] == RANGE_EXT;
         ext_b_q   <= unit_q[1][B_RANGE_HI:B_RANGE_LO] == RANGE_EXT;
      end
   end

   assign o_range_a         = range_a_q;
   assign o_range_b         = range_b_q;
   assign o_ext_range_sel_a = ext_a_q;
   assign o_ext_range_sel_b = ext_b_q;

   // open-drain flags: level is always low, enable decides
   logic [UNITS-1:0] over_oe_n_q;
   logic [UNITS-1:0] under_oe_n_q;
   logic [UNITS-1:0] flag_lvl_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         over_oe_n_q  <= 2'h3;
         under_oe_n_q <= 2'h3;
         flag_lvl_q   <= 2'h0;
      end else begin
         over_oe_n_q  <= ~(cmp_on & above_s);
         under_oe_n_q <= ~(cmp_on & below_s);
         flag_lvl_q   <= 2'h0;
      end
   end

   assign o_over_limit_flag_n  = flag_lvl_q;
   assign o_under_limit_flag_n = flag_lvl_q;
   assign o_over_limit_oe_n    = over_oe_n_q;
   assign o_under_limit_oe_n   = under_oe_n_q;

   a_shift_msb_in: assert property (!cs_n_s && sclk_rise |=>
      shift_q[0] == $past(din_s) && shift_q[15:1] == $past(shift_q[14:0]))
      else $error("shift register did not take serial input");

   a_dout_fall: assert property (sclk_fall |=> o_dout == $past(shift_q[15]))
      else $error("serial output not updated on falling edge");

   a_dout_hold: assert property (!sclk_fall |=> $stable(o_dout))
      else $error("serial output moved without falling edge");

   a_nop_word: assert property (cs_rise && active_q && shift_q[3:0] == 4'h0
      && load_n_s |=> in_q[0] == $past(in_q[0]) && in_q[1] == $past(in_q[1])
      && unit_q[0] == $past(unit_q[0]) && unit_q[1] == $past(unit_q[1]))
      else $error("nop word changed a register");

   a_addr_loads: assert property (cs_rise && active_q && addr[0]
      |=> in_q[0] == $past(shift_q))
      else $error("addressed input register not loaded");

   a_other_kept: assert property (cs_rise && addr == 2'h1
      |=> in_q[1] == $past(in_q[1]))
      else $error("unaddressed input register changed");

   a_hold_unit: assert property (cs_rise && active_q && xfer == 2'h0
      && load_n_s |=> unit_q[0] == $past(unit_q[0]) && unit_q[1] == $past(unit_q[1]))
      else $error("unit register moved with zero control");

   a_xfer_b: assert property (cs_rise && active_q && xfer[1]
      |=> unit_q[1] == in_q[1])
      else $error("unit register b not transferred");

   a_quick_load: assert property (cs_rise && !active_q
      |=> unit_q[0] == $past(in_q[0]) && unit_q[1] == $past(in_q[1]))
      else $error("quick load failed");

   a_load_pin: assert property (!load_n_s |=> unit_q[0] == in_q[0] && unit_q[1] == in_q[1])
      else $error("load pin did not copy input registers");

   a_force_float: assert property (!unit_q[0][8] |=> !o_force_drive[0])
      else $error("force driver not floated");

   a_meas_float: assert property (!mflt_s[1] |=> !o_measure_drive[1])
      else $error("measure output not floated by pin");

   a_range_ext: assert property (##1 o_ext_range_sel_a ==
      ($past(unit_q[0][12:10]) == 3'h6))
      else $error("external range select wrong");

   a_cmp_off: assert property (!cmp_on[0] |=>
      o_over_limit_oe_n[0] && o_under_limit_oe_n[0])
      else $error("disabled comparator still driving");

   a_cmp_high: assert property (cmp_on[1] && above_s[1] |=> !o_over_limit_oe_n[1])
      else $error("high flag not pulled low");

   a_xfer_a: assert property (cs_rise && active_q && xfer[0] |=>
      unit_q[0] == ($past(addr[0]) ? $past(shift_q) : $past(in_q[0])))
      else $error("unit register a not transferred");

   a_addr_b: assert property (cs_rise && active_q && addr[1]
      |=> in_q[1] == $past(shift_q))
      else $error("addressed input register b not loaded");

   a_in_select: assert property (1'b1 |=>
      o_input_select_bit == {$past(unit_q[1][15]), $past(unit_q[0][15])})
      else $error("input select output wrong");

   a_force_type: assert property (1'b1 |=>
      o_force_current == {$past(unit_q[1][14]), $past(unit_q[0][14])})
      else $error("force type output wrong");

   a_meas_type: assert property (1'b1 |=>
      o_measure_voltage == {$past(unit_q[1][13]), $past(unit_q[0][13])})
      else $error("measure type output wrong");

   a_clamp_bit: assert property (1'b1 |=>
      o_clamp_on == {$past(unit_q[1][9]), $past(unit_q[0][9])})
      else $error("clamp enable output wrong");

   a_range_20ua: assert property (unit_q[1][12:10] == 3'h2
      |=> o_range_b == 3'h1)
      else $error("range b code 010 decoded wrongly");

   a_range_seven: assert property (unit_q[0][12:10] == 3'h7
      |=> o_range_a == 3'h4 && !o_ext_range_sel_a)
      else $error("range a code 111 decoded wrongly");

   a_force_on: assert property (unit_q[1][8]
      |=> o_force_drive[1])
      else $error("force driver not enabled");

   a_cmp_low: assert property (cmp_on[0] && below_s[0]
      |=> !o_under_limit_oe_n[0])
      else $error("low flag not pulled low");

   a_cmp_release: assert property (!below_s[1]
      |=> o_under_limit_oe_n[1])
      else $error("low flag pulled low inside window");

   a_idle_shift: assert property (cs_n_s
      |=> $stable(shift_q))
      else $error("shift register moved with chip select high");

   a_pass_through: assert property (!load_n_s && in_ld[1]
      |=> unit_q[1] == $past(shift_q))
      else $error("latched data did not pass to unit register");

   a_unit_hold: assert property (!cs_rise && load_n_s
      |=> unit_q[0] == $past(unit_q[0]) && unit_q[1] == $past(unit_q[1]))
      else $error("unit register moved without a load");

endmodule

// ===== dpsc_host_model.sv
`timescale 1ns/1ps
module dpsc_host_model (
   input  wire logic i_clk,
   input  wire logic i_dout,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_din
);
   logic [15:0] rx;

   initial begin
      o_cs_n = 1'h1;
      o_sclk = 1'h0;
      o_din  = 1'h0;
      rx     = 16'h0000;
   end

   // four fast clocks a half keeps each sclk level above the 3-clock minimum
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask

   // n words, first word first; rx plays the next device in the chain
   task automatic frame(input logic [63:0] w, input int n);
      o_cs_n <= 1'h0;
      for (int i = 16 * n - 1; i >= 0; i--) begin
         o_din <= w[i];
         half();
         o_sclk <= 1'h1;
         rx     <= {rx[14:0], i_dout};
         half();
         o_sclk <= 1'h0;
      end
      half();
      o_cs_n <= 1'h1;
      o_din  <= ~o_din; // released line must not look like held data
      half();
   endtask

   task automatic quick_load();
      o_cs_n <= 1'h0;
      half();
      o_cs_n <= 1'h1;
      half();
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   import dpsc_pkg::*;
   logic        i_clk = 1'h0, i_reset = 1'h1, i_load_n = 1'h1;
   logic [1:0]  fpin = 2'h0, above = 2'h0, below = 2'h0;
   logic        cs_n, sclk, din, dout, ext_a, ext_b, ld;
   logic [1:0]  isel, fcur, mvolt, clamp, fdrv, mdrv, ovf, ovoe, unf, unoe;
   logic [2:0]  rng_a, rng_b;
   logic [15:0] ina = 16'h0000, inb = 16'h0000, ua = 16'h0000, ub = 16'h0000;
   logic [15:0] prev = 16'h0000, w, w2;
   int          err_count = 0, checks = 0, n;

   always #12.5 i_clk = ~i_clk;

   dpsc_host_model host (.i_clk(i_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

   dpsc_serial_ctrl uut (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
      .i_load_n(i_load_n), .i_measure_float_pin_n(fpin), .i_above_upper(above), .i_below_lower(below),
      .o_dout(dout), .o_input_select_bit(isel), .o_force_current(fcur), .o_measure_voltage(mvolt),
      .o_range_a(rng_a), .o_range_b(rng_b), .o_ext_range_sel_a(ext_a), .o_ext_range_sel_b(ext_b),
      .o_clamp_on(clamp), .o_force_drive(fdrv), .o_measure_drive(mdrv), .o_over_limit_flag_n(ovf),
      .o_over_limit_oe_n(ovoe), .o_under_limit_flag_n(unf), .o_under_limit_oe_n(unoe));

   function automatic logic [2:0] exp_rng(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: return 3'h0;
         3'h2:       return 3'h1;
         3'h3:       return 3'h2;
         3'h4:       return 3'h3;
         3'h6:       return 3'h5;
         default:    return 3'h4;
      endcase
   endfunction

   function automatic void apply(input logic [15:0] v);
      if (v[2]) ina = v;
      if (v[3]) inb = v;
      if (v[0]) ua = ina;
      if (v[1]) ub = inb;
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_all();
      logic [15:0] v;
      for (int u = 0; u < 2; u++) begin
         v = u ? ub : ua;
         chk(isel[u], v[B_IN_SEL]);
         chk(fcur[u], v[B_FORCE_TYPE]);
         chk(mvolt[u], v[B_MEAS_TYPE]);
         chk(u ? rng_b : rng_a, exp_rng(v[12:10]));
         chk(u ? ext_b : ext_a, v[12:10] == 3'h6);
         chk(clamp[u], v[B_CLAMP]);
         chk(fdrv[u], v[B_FORCE_FLT]);
         chk(mdrv[u], v[B_MEAS_FLT] & fpin[u]);
         chk(ovoe[u], !(v[B_CMP_EN] & above[u]));
         chk(unoe[u], !(v[B_CMP_EN] & below[u]));
         chk({ovf[u], unf[u]}, 16'h0000);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      err_count++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'h5427F023));
      repeat (16) @(posedge i_clk);
      i_reset <= 1'h0;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      check_all();
      $display("test reset done");
      for (int t = 0; t < 48; t++) begin
         @(posedge i_clk);
         fpin     <= 2'($urandom);
         above    <= 2'($urandom);
         below    <= 2'($urandom);
         // first 16 passes walk every address and control code with load idle
         ld       = (t >= 16) && ($urandom % 4 == 0);
         i_load_n <= !ld;
         w        = 16'($urandom);
         w2       = 16'($urandom);
         if (t < 16) w[3:0] = 4'(t);
         if (ld) begin
            ua = ina;
            ub = inb;
         end
         if (t >= 16 && t % 7 == 6) begin
            host.quick_load();
            ua = ina;
            ub = inb;
         end else begin
            n = (t % 9 == 8) ? 2 : 1;
            host.frame({32'h0000_0000, w2, w}, n);
            chk(host.rx, n == 2 ? w2 : prev);
            prev = w;
            apply(w);
         end
         if (ld) begin
            ua = ina;
            ub = inb;
         end
         repeat (8) @(posedge i_clk);
         @(negedge i_clk);
         check_all();
         $display("test %0d done", t);
      end
      report_and_stop();
   end
endmodule
